//--- shared/tec1_pkg.sv
package tec1_pkg;
  // ----------------------------------------------------------------
  // Register map (offsets 10H, 11H are word indices)
  // ----------------------------------------------------------------
  localparam logic [7:0] TEC1_IDX_COUNT = 8'h10;
  localparam logic [7:0] TEC1_IDX_CTRL = 8'h11;
  localparam logic [7:0] TEC1_IDX_INTERRUPT_CONTROL_REG = 8'h12;
  localparam logic [11:0] TEC1_ADDR_COUNT = {2'b00, TEC1_IDX_COUNT, 2'b00};
  localparam logic [11:0] TEC1_ADDR_CTRL = {2'b00, TEC1_IDX_CTRL, 2'b00};
  localparam logic [11:0] TEC1_ADDR_INTERRUPT_CONTROL_REG = {2'b00, TEC1_IDX_INTERRUPT_CONTROL_REG, 2'b00};
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TEC1_EDGE_BIT = 3;
  localparam int TEC1_EN_BIT = 4;
  localparam int TEC1_SRC_BIT = 5;
  localparam int TEC1_FLAG_BIT = 6;
  localparam int TEC1_IE_BIT = 0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TEC1_CTRL_RST = 8'h00;
  localparam logic [7:0] TEC1_COUNT_RST = 8'h00;
  localparam logic [7:0] TEC1_MAX = 8'hFF;
  localparam logic [4:0] TEC1_RTC_DIV = 5'h1F;
  localparam logic [7:0] TEC1_PRE_RST = 8'h00;

  typedef enum logic [1:0] {
    TEC1_M_NONE = 2'b00,
    TEC1_M_EVENT = 2'b01,
    TEC1_M_TIMER = 2'b10,
    TEC1_M_PULSE = 2'b11
  } tec1_mode_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] preload;
    logic [7:0] count;
    logic [7:0] prescale;
    logic [4:0] rtc_div;
    logic ie;
    logic flag;
    logic in_s1;
    logic in_s2;
    logic in_d;
    logic pw_run;
    logic wake;
    logic irq;
    logic pready;
    logic [31:0] prdata;
  } tec1_state_t;
endpackage

//--- logic/tec1_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Source bit 0 picks system clock, 1 picks the real-time clock.
// RULE2: Prescaler divides source by 2 (code 000) up to 256 (code 111).
// RULE3: Mode 01 event count, 10 timer, 11 pulse width, 00 idle.
// RULE4: Event mode counts transitions of the external input pin.
// RULE5: Timer and pulse-width modes count the prescaled clock.
// RULE6: Event mode polarity 1 counts falling edges, 0 rising edges.
// RULE7: Event and timer modes count up from current value to FFH.
// RULE8: Overflow reloads from preload and sets the request flag bit 6.
// RULE9: Counting runs only while enable bit 4 of control is 1.
// RULE10: Pulse mode polarity 1 starts on rise, stops on fall; 0 reversed.
// RULE11: Pulse measurement starts on an edge, not on a level.
// RULE12: End of a pulse measurement clears the enable bit itself.
// RULE13: Captured count is held until software enables again.
// RULE14: Pulse mode overflow reloads and requests like other modes.
// RULE15: Event and timer modes never clear enable by themselves.
// RULE16: Write while enabled updates only preload; count runs on.
// RULE17: Every count write replaces preload; latest write wins.
// RULE18: Write while disabled loads both preload and counter.
// RULE19: Reading count register returns the counter, not the preload.
// RULE20: Counting is blocked during a count register read.
// RULE21: Overflow gives a wake-up pulse out of halt.
// RULE22: Interrupt enable 0 keeps the overflow off the interrupt line.
// RULE23: Selected source feeds the prescaler directly.
// RULE24: Pin is synchronised before edge detection, one event per edge.
module tec1_top
  import tec1_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rtc_tick,
  input wire logic counter_value_and_input_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic overflow_request_flag,
  output logic overflow_irq,
  output logic wake_pulse
);
  tec1_state_t s_r;
  tec1_state_t s_nxt;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  tec1_mode_t mode;
  logic en;
  logic pol;
  logic src_tick;
  logic pre_tick;
  logic rise;
  logic fall;
  logic acc;
  logic wr;
  logic rd_cnt;
  logic wr_cnt;
  logic adv;
  logic ovf;
  logic pw_start;
  logic pw_stop;
  logic [7:0] pre_inc;

  assign mode = tec1_mode_t'(s_r.ctrl[7:6]);
  assign en = s_r.ctrl[TEC1_EN_BIT];
  assign pol = s_r.ctrl[TEC1_EDGE_BIT];
  assign acc = psel & penable & ~s_r.pready;
  assign wr = acc & pwrite;
  assign wr_cnt = wr & (paddr == TEC1_ADDR_COUNT);
  // Block counting over the whole read transfer
  assign rd_cnt = psel & ~pwrite & (paddr == TEC1_ADDR_COUNT); // RULE20
  assign rise = s_r.in_s2 & ~s_r.in_d; // RULE24
  assign fall = ~s_r.in_s2 & s_r.in_d; // RULE24
  // System source ticks every cycle; RTC source waits for its pulse
  assign src_tick = s_r.ctrl[TEC1_SRC_BIT] ? rtc_tick : 1'b1; // RULE1
  assign pre_inc = s_r.prescale + (src_tick ? 8'h01 : 8'h00); // RULE23
  // Ratio 2^(code+1): tick when low code+1 bits wrap to zero
  always_comb begin
    pre_tick = 1'b0;
    if (src_tick) begin
      pre_tick = 1'b1;
      for (int i = 0; i < 8; i++) begin
        if (i <= int'(s_r.ctrl[2:0]) && pre_inc[i]) begin
          pre_tick = 1'b0; // RULE2
        end
      end
    end
  end

  assign pw_start = (mode == TEC1_M_PULSE) & en & ~s_r.pw_run &
                    (pol ? rise : fall); // RULE10 RULE11
  assign pw_stop = (mode == TEC1_M_PULSE) & en & s_r.pw_run &
                   (pol ? fall : rise); // RULE10

  always_comb begin
    adv = 1'b0;
    case (mode)
      TEC1_M_EVENT: adv = pol ? fall : rise; // RULE4 RULE6
      TEC1_M_TIMER: adv = pre_tick; // RULE5
      TEC1_M_PULSE: adv = pre_tick & s_r.pw_run & ~pw_stop; // RULE5
      default: adv = 1'b0; // RULE3
    endcase
    adv = adv & en & ~rd_cnt; // RULE9 RULE20
  end
  assign ovf = adv & (s_r.count == TEC1_MAX); // RULE7

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.in_s1 = counter_value_and_input_pin;
    s_nxt.in_s2 = s_r.in_s1;
    s_nxt.in_d = s_r.in_s2;
    s_nxt.wake = ovf; // RULE21
    s_nxt.pready = acc;
    if (src_tick) begin
      s_nxt.prescale = pre_inc;
    end
    if (adv) begin
      s_nxt.count = ovf ? s_r.preload : s_r.count + 8'h01; // RULE7 RULE8 RULE14
    end
    if (pw_start) begin
      s_nxt.pw_run = 1'b1;
    end
    if (pw_stop) begin
      s_nxt.pw_run = 1'b0;
      s_nxt.ctrl[TEC1_EN_BIT] = 1'b0; // RULE12 RULE13 RULE15
    end
    if (wr_cnt) begin
      s_nxt.preload = pwdata[7:0]; // RULE16 RULE17
      if (!en) begin
        s_nxt.count = pwdata[7:0]; // RULE18
      end
    end
    if (wr && paddr == TEC1_ADDR_CTRL) begin
      s_nxt.ctrl = pwdata[7:0];
      s_nxt.pw_run = 1'b0;
    end
    if (wr && paddr == TEC1_ADDR_INTERRUPT_CONTROL_REG) begin
      s_nxt.ie = pwdata[TEC1_IE_BIT];
      s_nxt.flag = pwdata[TEC1_FLAG_BIT];
    end
    if (ovf) begin
      s_nxt.flag = 1'b1; // RULE8
    end
    s_nxt.irq = s_nxt.flag & s_nxt.ie; // RULE22
    s_nxt.prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      case (paddr)
        TEC1_ADDR_COUNT: s_nxt.prdata = {24'h000000, s_r.count}; // RULE19
        TEC1_ADDR_CTRL: s_nxt.prdata = {24'h000000, s_r.ctrl};
        TEC1_ADDR_INTERRUPT_CONTROL_REG: s_nxt.prdata = {25'h0000000, s_r.flag,
                                        5'h00, s_r.ie};
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = 1'b0;
  assign overflow_request_flag = s_r.flag;
  assign overflow_irq = s_r.irq;
  assign wake_pulse = s_r.wake;
endmodule

//--- bench/tec1_pin_model.sv
`timescale 1ns/1ps
module tec1_pin_model (
  input wire logic clk,
  input wire logic go,
  output logic pin
);
  logic [1:0] cnt;
  // Pin idles low; while go, it toggles every 4 clocks
  always_ff @(posedge clk) begin
    cnt <= go ? cnt + 2'h1 : 2'h0;
    if (!go) pin <= 1'b0;
    else if (cnt == 2'h3) pin <= ~pin;
  end
endmodule

//--- bench/tec1_assertions.sv
`timescale 1ns/1ps
module tec1_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic overflow_request_flag,
  input wire logic overflow_irq,
  input wire logic wake_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  a_irq_gate: assert property (overflow_irq |-> overflow_request_flag)
    else $error("irq without flag");
  a_wake_once: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake longer than one cycle");
  // Software may set the flag by a write, so skip rises during access
  a_flag_wake: assert property (
    $rose(overflow_request_flag) && !(psel && penable) |-> wake_pulse)
    else $error("overflow without wake");
  a_wake_flag: assert property (wake_pulse |-> overflow_request_flag)
    else $error("wake without flag");
  a_ready_one: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_rdata_wide: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  c_flag: cover property ($rose(overflow_request_flag));
  c_irq: cover property ($rose(overflow_irq));
  c_wake: cover property (wake_pulse);
endmodule

//--- bench/tb_tec1_top.sv
`timescale 1ns/1ps
module tb_tec1_top;
  import tec1_pkg::*;
  logic clk = 0, rst_b = 0, rtc_tick = 0, psel = 0, penable = 0;
  logic pwrite = 0, go = 0, pin, pslverr, flag, irq, wake, pready;
  logic tick_on = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, r1;
  logic [4:0] tc = 5'h0;
  int err_count = 0, n_checks = 0, i;
  tec1_top dut_u (.clk(clk), .rst_b(rst_b), .rtc_tick(rtc_tick),
    .counter_value_and_input_pin(pin), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .overflow_request_flag(flag),
    .overflow_irq(irq), .wake_pulse(wake));
  tec1_pin_model pin_u (.clk(clk), .go(go), .pin(pin));
  initial forever #50 clk = ~clk;
  // Slow source tick so a register access never races a count step
  always @(posedge clk) begin
    tc <= tc + 5'h1;
    rtc_tick <= tick_on && (tc == 5'h1F);
  end
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
    if (i == 20) begin
      err_count++;
      finish_test();
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task pulses(input int n);
    @(posedge clk);
    go <= 1;
    repeat (n) @(posedge clk);
    go <= 0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    apb(0, TEC1_ADDR_CTRL, 0); chk(rd, 32'h0);
    apb(0, TEC1_ADDR_COUNT, 0); chk(rd, 32'h0);
    apb(0, 12'h04C, 0); chk(rd, 32'h0);
    $display("reset test done");
    for (int p = 0; p < 2; p++) begin
      apb(1, TEC1_ADDR_COUNT, 32'h3);
      apb(1, TEC1_ADDR_CTRL, 32'h50 | (p << 3));
      pulses(40);
      apb(0, TEC1_ADDR_COUNT, 0); chk(rd, 32'h8);
      apb(1, TEC1_ADDR_CTRL, 32'h0);
    end
    $display("event test done");
    apb(1, TEC1_ADDR_INTERRUPT_CONTROL_REG, 32'h1);
    apb(1, TEC1_ADDR_COUNT, 32'hFE);
    apb(1, TEC1_ADDR_CTRL, 32'hB0);
    apb(1, TEC1_ADDR_COUNT, 32'h33);
    apb(1, TEC1_ADDR_COUNT, 32'h22);
    apb(0, TEC1_ADDR_COUNT, 0); chk(rd, 32'hFE);
    tick_on <= 1;
    for (i = 0; i < 400 && flag !== 1'b1; i++) @(posedge clk);
    chk(flag, 1'b1);
    if (i == 400) finish_test();
    apb(0, TEC1_ADDR_COUNT, 0); chk(rd, 32'h22);
    chk(irq, 1'b1);
    apb(0, TEC1_ADDR_CTRL, 0); chk(rd, 32'hB0);
    apb(1, TEC1_ADDR_INTERRUPT_CONTROL_REG, 32'h0);
    apb(1, TEC1_ADDR_CTRL, 32'h0);
    $display("timer test done");
    apb(1, TEC1_ADDR_COUNT, 32'h5);
    apb(1, TEC1_ADDR_CTRL, 32'h10);
    pulses(16);
    apb(0, TEC1_ADDR_COUNT, 0); chk(rd, 32'h5);
    chk(pslverr, 1'b0);
    apb(1, TEC1_ADDR_CTRL, 32'h0);
    $display("idle mode test done");
    apb(1, TEC1_ADDR_COUNT, 32'h0);
    apb(1, TEC1_ADDR_CTRL, 32'hD8);
    pulses(8);
    apb(0, TEC1_ADDR_CTRL, 0); chk(rd, 32'hC8);
    apb(0, TEC1_ADDR_COUNT, 0);
    r1 = rd;
    pulses(8);
    apb(0, TEC1_ADDR_COUNT, 0); chk(rd, r1);
    $display("pulse test done");
    finish_test();
  end
endmodule
bind tec1_top tec1_assertions chk_u (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .overflow_request_flag(overflow_request_flag),
  .overflow_irq(overflow_irq), .wake_pulse(wake_pulse));
